// file: rtl/drc_ref_ctrl.sv
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`include "drc_consts.svh"
module drc_ref_ctrl #(
  parameter int CODE_W = 12,
  parameter int NCH    = 8
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  input  wire logic                 clk_en,
  // package and format straps
  input  wire logic                 small_package,
  input  wire logic                 code_format_select,
  // axi4-lite write address
  input  wire logic [3:0]           s_awaddr,
  input  wire logic                 s_awvalid,
  output logic                      s_awready,
  // axi4-lite write data
  input  wire logic [31:0]          s_wdata,
  input  wire logic [3:0]           s_wstrb,
  input  wire logic                 s_wvalid,
  output logic                      s_wready,
  // axi4-lite write response
  output logic [1:0]                s_bresp,
  output logic                      s_bvalid,
  input  wire logic                 s_bready,
  // axi4-lite read
  input  wire logic [3:0]           s_araddr,
  input  wire logic                 s_arvalid,
  output logic                      s_arready,
  output logic [31:0]               s_rdata,
  output logic [1:0]                s_rresp,
  output logic                      s_rvalid,
  input  wire logic                 s_rready,
  // reference and datapath outputs
  output logic                      ref_enabled,
  output logic                      reference_gain_divider,
  output logic                      shared_reference_pin_oe,
  output logic [CODE_W-1:0]         string_tap
);
  import drc_pkg::*;

  // ****************************************************
  // reset synchroniser
  // ****************************************************
  logic rst_m;
  logic rst_q;
  // every check below runs on the core clock, idle while in reset
  default clocking drc_chk_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_q);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_m <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_q <= rst_m;
    end
  end

  // ****************************************************
  // helpers
  // ****************************************************
  // decoded reference action of one 24-bit command word
  function automatic logic [2:0] cmd_decode(input drc_cmd_t c,
                                            input logic flex);
    logic [3:0] nib;
    nib = c[`DRC_CMD_MSB:`DRC_CMD_LSB];
    cmd_decode = 3'b000; // bit0 valid, bit1 go_flex, bit2 go_static
    if (nib == `DRC_CMD_STATIC && !flex) begin
      cmd_decode = 3'b001;
    end else if (nib == `DRC_CMD_FLEX) begin
      if (c[`DRC_FLEX_BIT]) begin
        cmd_decode = 3'b011;
      end else begin
        cmd_decode = 3'b101;
      end
    end
  endfunction : cmd_decode

  // ****************************************************
  // bus slave
  // ****************************************************
  logic              aw_hold;
  logic              w_hold;
  logic [3:0]        aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              next_aw_hold;
  logic              next_w_hold;
  logic [3:0]        next_aw_addr;
  logic [31:0]       next_w_data;
  logic [3:0]        next_w_strb;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_rvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic              wr_fire;
  drc_cmd_t          cmd_word;
  logic [CODE_W-1:0] code_reg;
  logic [NCH-1:0]    chan_up;
  drc_ref_e          ref_state;
  logic              flex_mode;
  // one write and one read in flight; a write completes only
  // once both halves are in and the response slot is free
  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold  = w_hold;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_bvalid;
    next_bresp   = s_bresp;
    next_rvalid  = s_rvalid;
    next_rdata   = s_rdata;
    next_rresp   = s_rresp;
    wr_fire      = 1'b0;
    if (s_awvalid && s_awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      next_w_hold = 1'b1;
      next_w_data = s_wdata;
      next_w_strb = s_wstrb;
    end
    if (s_bvalid && s_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_hold && w_hold && !s_bvalid) begin
      wr_fire      = 1'b1;
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (aw_addr == `DRC_OFF_STAT || aw_addr[1:0] != 2'b00
                      || aw_addr > `DRC_OFF_PWR) ? 2'b10 : 2'b00;
    end
    if (s_rvalid && s_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_arvalid && s_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = 2'b00;
      unique case (s_araddr)
        `DRC_OFF_CMD:  next_rdata = {8'h00, cmd_word};
        `DRC_OFF_STAT: next_rdata = {26'h000_0000, flex_mode,
                                     ref_state, reference_gain_divider,
                                     ref_enabled};
        `DRC_OFF_CODE: next_rdata = {20'h0_0000, code_reg};
        `DRC_OFF_PWR:  next_rdata = {{(32-NCH){1'b0}}, chan_up};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = 2'b10;
        end
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      aw_hold  <= 1'b0;
      w_hold   <= 1'b0;
      aw_addr  <= 4'h0;
      w_data   <= 32'h0000_0000;
      w_strb   <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp  <= 2'b00;
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= 2'b00;
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_arready <= 1'b0;
    end else if (clk_en) begin
      aw_hold  <= next_aw_hold;
      w_hold   <= next_w_hold;
      aw_addr  <= next_aw_addr;
      w_data   <= next_w_data;
      w_strb   <= next_w_strb;
      s_bvalid <= next_bvalid;
      s_bresp  <= next_bresp;
      s_rvalid <= next_rvalid;
      s_rdata  <= next_rdata;
      s_rresp  <= next_rresp;
      // ready only while the holding slot is empty: back-pressure
      s_awready <= !next_aw_hold;
      s_wready  <= !next_w_hold;
      s_arready <= !next_rvalid;
    end
  end

  // ****************************************************
  // command interpreter and reference state
  // ****************************************************
  logic [CODE_W-1:0] next_code;
  logic [NCH-1:0]    next_chan;
  drc_cmd_t          next_cmd;
  drc_ref_e          next_ref;
  logic              next_flex;
  logic [2:0]        dec;
  logic              full_cmd;
  // a command acts only when all three command bytes were
  // written in one beat; partial strobes change nothing
  always_comb begin
    next_code = code_reg;
    next_chan = chan_up;
    next_cmd  = cmd_word;
    next_ref  = ref_state;
    next_flex = flex_mode;
    full_cmd  = (w_strb[2:0] == 3'b111);
    dec       = cmd_decode(w_data[23:0], flex_mode);
    if (wr_fire && aw_addr == `DRC_OFF_CODE && w_strb[1:0] == 2'b11) begin
      next_code = w_data[CODE_W-1:0];
    end
    if (wr_fire && aw_addr == `DRC_OFF_PWR && w_strb[0]) begin
      next_chan = w_data[NCH-1:0];
    end
    if (wr_fire && aw_addr == `DRC_OFF_CMD && full_cmd && dec[0]) begin
      next_cmd = w_data[23:0];
      if (dec[2]) begin
        next_flex = 1'b0;
      end else if (dec[1]) begin
        next_flex = 1'b1;
        unique case ({w_data[`DRC_CTRL_HI_BIT], w_data[`DRC_CTRL_LO_BIT]})
          2'b00: next_ref = DRC_TRACK;
          2'b01: next_ref = DRC_ALWAYS;
          2'b10: next_ref = w_data[`DRC_REF_ON_BIT] ? ref_state
                                                    : DRC_OFF;
          2'b11: next_ref = ref_state;
        endcase
      end else begin
        next_ref = w_data[`DRC_REF_ON_BIT] ? DRC_TRACK : DRC_OFF;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      code_reg  <= `DRC_RST_CODE;
      chan_up   <= `DRC_RST_PWR;
      cmd_word  <= 24'h00_0000;
      ref_state <= DRC_OFF;
      flex_mode <= 1'b0;
    end else if (clk_en) begin
      code_reg  <= next_code;
      chan_up   <= next_chan;
      cmd_word  <= next_cmd;
      ref_state <= next_ref;
      flex_mode <= next_flex;
    end
  end

  // ****************************************************
  // reference power, gain and code format outputs
  // ****************************************************
  logic              next_en;
  logic [CODE_W-1:0] next_tap;
  always_comb begin
    unique case (ref_state)
      DRC_TRACK:  next_en = |chan_up;
      DRC_ALWAYS: next_en = 1'b1;
      default:    next_en = 1'b0;
    endcase
    // two's complement maps to offset binary by msb flip
    next_tap           = code_reg;
    next_tap[CODE_W-1] = code_reg[CODE_W-1]
                         ^ (!small_package && code_format_select);
  end
  always_ff @(posedge ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      ref_enabled             <= 1'b0;
      reference_gain_divider  <= 1'b0;
      shared_reference_pin_oe <= 1'b0;
      string_tap              <= `DRC_RST_CODE;
    end else if (clk_en) begin
      ref_enabled             <= next_en;
      reference_gain_divider  <= next_en;
      shared_reference_pin_oe <= next_en;
      string_tap              <= next_tap;
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  // gain judged from the reference state, not from the enable flop
  gain_follows_ref_a: assert property (clk_en |=>
    reference_gain_divider == ($past(ref_state) == DRC_ALWAYS
    || ($past(ref_state) == DRC_TRACK && |$past(chan_up))))
    else $error("gain divider disagrees with reference state");
  pin_driver_off_a: assert property (clk_en && ref_state == DRC_OFF
    |=> !shared_reference_pin_oe)
    else $error("reference pin driven while disabled");
  always_track_a: assert property (clk_en && ref_state == DRC_ALWAYS
    |=> ref_enabled)
    else $error("always-on reference dropped");
  track_down_a: assert property (clk_en && ref_state == DRC_TRACK
    && chan_up == '0 |=> !ref_enabled)
    else $error("tracking reference stayed up");
  track_up_a: assert property (clk_en && ref_state == DRC_TRACK
    && |chan_up |=> ref_enabled)
    else $error("tracking reference stayed down");
  static_ignored_a: assert property (clk_en && flex_mode && wr_fire
    && w_data[`DRC_CMD_MSB:`DRC_CMD_LSB] == `DRC_CMD_STATIC
    |=> $stable(ref_state) && flex_mode)
    else $error("static command acted in flexible mode");
  partial_ignored_a: assert property (clk_en && wr_fire && !full_cmd
    |=> $stable(ref_state))
    else $error("partial command changed reference");
  flex_enable_a: assert property (clk_en && wr_fire && full_cmd
    && aw_addr == `DRC_OFF_CMD && w_data[23:20] == `DRC_CMD_FLEX
    && w_data[14:12] == 3'b100 |=> ref_state == DRC_TRACK && flex_mode)
    else $error("flexible enable not taken");
  back_static_a: assert property (clk_en && wr_fire && full_cmd
    && aw_addr == `DRC_OFF_CMD && w_data[23:20] == `DRC_CMD_FLEX
    && !w_data[14] |=> !flex_mode)
    else $error("return to static not taken");
endmodule : drc_ref_ctrl

// file: rtl/drc_consts.svh
`ifndef DRC_CONSTS_SVH
`define DRC_CONSTS_SVH
// command nibble codes
`define DRC_CMD_STATIC   4'h8
`define DRC_CMD_FLEX     4'h9
// field positions inside the 24-bit command word
`define DRC_CMD_MSB      23
`define DRC_CMD_LSB      20
`define DRC_FLEX_BIT     14
`define DRC_CTRL_HI_BIT  13
`define DRC_CTRL_LO_BIT  12
`define DRC_REF_ON_BIT   4
// code range
`define DRC_CODE_MAX     12'hfff
`define DRC_CODE_STEPS   4096
// axi-lite byte offsets
`define DRC_OFF_CMD      4'h0
`define DRC_OFF_STAT     4'h4
`define DRC_OFF_CODE     4'h8
`define DRC_OFF_PWR      4'hc
// reset values
`define DRC_RST_CODE     12'h000
`define DRC_RST_PWR      8'h00
`endif

// file: rtl/drc_pkg.sv
`include "drc_consts.svh"
package drc_pkg;
  typedef enum logic [2:0] {
    DRC_OFF    = 3'b001,
    DRC_TRACK  = 3'b010,
    DRC_ALWAYS = 3'b100
  } drc_ref_e;
  typedef logic [23:0] drc_cmd_t;
endpackage : drc_pkg

// file: testbench/drc_axi_master.sv
// ****************************************
// axi4-lite master standing in for the host
// ****************************************
module drc_axi_master (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // one request from the bench, pulse go
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  strb,
  output logic             done,
  output logic [1:0]       resp,
  output logic [31:0]      rdata,
  // axi4-lite master side
  output logic [3:0]       s_awaddr,
  output logic             s_awvalid,
  input  wire logic        s_awready,
  output logic [31:0]      s_wdata,
  output logic [3:0]       s_wstrb,
  output logic             s_wvalid,
  input  wire logic        s_wready,
  input  wire logic [1:0]  s_bresp,
  input  wire logic        s_bvalid,
  output logic             s_bready,
  output logic [3:0]       s_araddr,
  output logic             s_arvalid,
  input  wire logic        s_arready,
  input  wire logic [31:0] s_rdata,
  input  wire logic [1:0]  s_rresp,
  input  wire logic        s_rvalid,
  output logic             s_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // each channel holds until its own ready; address and data inverted once taken, strobes kept
  // so a slave that samples address or data late never sees the old value
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      {s_awvalid, s_wvalid, s_arvalid, s_bready, s_rready} <= 5'h0;
      {s_awaddr, s_araddr, s_wstrb} <= 12'h000;
      s_wdata <= 32'h0000_0000;
      {done, resp, rdata} <= 35'h0_0000_0000;
    end else begin
      done <= 1'b0;
      if (go && wr) begin
        // whole 24-bit command travels in one word, raised in the same cycle as the address
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        s_awaddr  <= addr;
        s_wdata   <= wdata;
        s_wstrb   <= strb;
      end
      if (go && !wr) begin
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        s_araddr  <= addr;
      end
      if (s_awvalid && s_awready) begin
        s_awvalid <= 1'b0;
        s_awaddr  <= ~s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        s_wvalid <= 1'b0;
        s_wdata  <= ~s_wdata;
      end
      if (s_arvalid && s_arready) begin
        s_arvalid <= 1'b0;
        s_araddr  <= ~s_araddr;
      end
      if (s_bready && s_bvalid) begin
        s_bready <= 1'b0;
        done     <= 1'b1;
        resp     <= s_bresp;
      end
      if (s_rready && s_rvalid) begin
        s_rready <= 1'b0;
        done     <= 1'b1;
        resp     <= s_rresp;
        rdata    <= s_rdata;
      end
    end
  end
endmodule : drc_axi_master

// file: testbench/test_dac_reference_control.sv
`include "drc_consts.svh"
module test_dac_reference_control;
  timeunit 1ns;
  timeprecision 1ps;
  import drc_pkg::*;
  logic ref_clk, rstn, clk_en, small_package, code_format_select;
  logic [3:0] s_awaddr, s_araddr, s_wstrb, addr, strb;
  logic [31:0] s_wdata, s_rdata, wdata, rdata;
  logic [1:0] s_bresp, s_rresp, resp;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, go, wr, done;
  logic ref_enabled, reference_gain_divider, shared_reference_pin_oe;
  logic [11:0] string_tap, c;
  logic [35:0] notes[$];
  logic [35:0] n;
  int n_mismatch, checked, cyc, i, j;
  // ****************************************
  // design and host model
  // ****************************************
  drc_ref_ctrl drc_ref_ctrl_i (.ref_clk(ref_clk), .rstn(rstn),
    .clk_en(clk_en), .small_package(small_package),
    .code_format_select(code_format_select), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .ref_enabled(ref_enabled),
    .reference_gain_divider(reference_gain_divider),
    .shared_reference_pin_oe(shared_reference_pin_oe),
    .string_tap(string_tap));
  drc_axi_master drc_axi_master_i (.ref_clk(ref_clk), .rstn(rstn),
    .go(go), .wr(wr), .addr(addr), .wdata(wdata), .strb(strb),
    .done(done), .resp(resp), .rdata(rdata), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready));
  always #10 ref_clk = ~ref_clk;
  // ****************************************
  // checking helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  // status word: flex, one-hot state, gain, enable (gain follows enable)
  function automatic logic [31:0] st(input logic f, input drc_ref_e s,
                                     input logic en);
    return {26'h0, f, s, en, en};
  endfunction : st
  // command word with given command nibble, control bits and ref-on bit, random don't-care data bits
  function automatic logic [31:0] mk(input logic [3:0] nb,
                                     input logic [2:0] f, input logic on);
    logic [31:0] r;
    r = $urandom;
    return {8'h00, nb, r[19:15], f, r[11:5], on, r[3:0]};
  endfunction : mk
  // note: {output check, data check, resp, data}
  task automatic xfer(input logic w, input logic [3:0] a,
    input logic [31:0] d, input logic [3:0] s, input logic [1:0] er,
    input logic [31:0] e, input logic oc);
    int k;
    notes.push_back({oc, !w, er, e});
    go <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    strb <= s;
    @(posedge ref_clk);
    go <= 1'b0;
    for (k = 0; k < 60 && done !== 1'b1; k++) @(posedge ref_clk);
    // a transfer with no answer is a fault, not a skip
    if (done !== 1'b1) begin
      n_mismatch++;
      $display("Error at %0t: transfer got no answer", $time);
    end
    repeat (2) @(posedge ref_clk);
  endtask : xfer
  // write one register, then read back the status word
  task automatic wst(input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [31:0] e);
    xfer(1'b1, a, d, s, 2'b00, 32'h0, 1'b0);
    xfer(1'b0, `DRC_OFF_STAT, 32'h0, 4'h0, 2'b00, e, 1'b1);
  endtask : wst
  // result watcher: oldest note against each finished transfer
  always @(posedge ref_clk) begin
    if (done === 1'b1 && notes.size() > 0) begin
      n = notes.pop_front();
      check({30'h0, resp}, {30'h0, n[33:32]});
      if (n[34]) check(rdata, n[31:0]);
      if (n[35]) check({29'h0, ref_enabled, reference_gain_divider,
        shared_reference_pin_oe}, {29'h0, n[0], n[1], n[0]});
    end
  end
  // hang guard, a few hundred cycles of traffic expected
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {ref_clk, rstn, go, wr, small_package, code_format_select} = 6'h00;
    {addr, strb, wdata} = 40'h0;
    clk_en = 1'b1;
    void'($urandom(32'h9fd99dd9));
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    xfer(1'b0, `DRC_OFF_STAT, 32'h0, 4'h0, 2'b00, st(0, DRC_OFF, 0), 1);
    wst(`DRC_OFF_PWR, 32'hff, 4'hf, st(0, DRC_OFF, 0));
    wst(`DRC_OFF_CMD, mk(4'h8, 3'b111, 1), 4'hf, st(0, DRC_TRACK, 1));
    wst(`DRC_OFF_PWR, 32'h00, 4'hf, st(0, DRC_TRACK, 0));
    wst(`DRC_OFF_PWR, 32'h1 << $urandom_range(7), 4'hf,
        st(0, DRC_TRACK, 1));
    wst(`DRC_OFF_CMD, mk(4'h8, 3'b010, 0), 4'hf, st(0, DRC_OFF, 0));
    wst(`DRC_OFF_CMD, mk(4'h9, 3'b100, 0), 4'hf, st(1, DRC_TRACK, 1));
    wst(`DRC_OFF_CMD, mk(4'h8, 3'b000, 0), 4'hf, st(1, DRC_TRACK, 1));
    wst(`DRC_OFF_CMD, mk(4'h9, 3'b101, 0), 4'hf, st(1, DRC_ALWAYS, 1));
    wst(`DRC_OFF_PWR, 32'h00, 4'hf, st(1, DRC_ALWAYS, 1));
    wst(`DRC_OFF_CMD, mk(4'h9, 3'b110, 0), 4'hf, st(1, DRC_OFF, 0));
    wst(`DRC_OFF_CMD, mk(4'h8, 3'b111, 1), 4'hf, st(1, DRC_OFF, 0));
    wst(`DRC_OFF_CMD, mk(4'h9, 3'b011, 1), 4'hf, st(0, DRC_OFF, 0));
    wst(`DRC_OFF_PWR, 32'hff, 4'hf, st(0, DRC_OFF, 0));
    wst(`DRC_OFF_CMD, mk(4'h8, 3'b000, 1), 4'h3, st(0, DRC_OFF, 0));
    wst(`DRC_OFF_CMD, mk(4'h9, 3'b100, 0), 4'h3, st(0, DRC_OFF, 0));
    // misaligned read and write to the read-only status word
    xfer(1'b0, 4'h2, 32'h0, 4'h0, 2'b10, 32'h0, 1'b0);
    xfer(1'b1, `DRC_OFF_STAT, 32'h3f, 4'hf, 2'b10, 32'h0, 1'b0);
    // code extremes and a random code under three of the four strap settings
    for (i = 0; i < 3; i++) begin
      c = (i == 0) ? 12'h000 : (i == 1) ? `DRC_CODE_MAX : 12'($urandom);
      for (j = 0; j < 3; j++) begin
        small_package <= (j == 0);
        code_format_select <= (j != 1);
        xfer(1'b1, `DRC_OFF_CODE, {20'h0, c}, 4'hf, 2'b00, 32'h0, 1'b0);
        xfer(1'b0, `DRC_OFF_CODE, 32'h0, 4'h0, 2'b00, {20'h0, c}, 0);
        check({20'h0, string_tap}, {20'h0, (j == 2) ? c ^ 12'h800 : c});
      end
    end
    // clock enable low must hold the tap although the strap moves
    clk_en <= 1'b0;
    code_format_select <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check({20'h0, string_tap}, {20'h0, c ^ 12'h800});
    clk_en <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check({20'h0, string_tap}, {20'h0, c});
    // every noted answer must have arrived
    check(32'(notes.size()), 32'h0000_0000);
    complete_run();
  end
endmodule : test_dac_reference_control
